// file: verilog/fhi_flash_front.sv
// host-facing front end of a sequential flash with two page buffers
`timescale 1ns/1ps
`default_nettype none
module fhi_flash_front import fhi_pkg::*; #(
  parameter int          PAGES   = 8192,
  parameter logic [63:0] ID_SEED = 64'h5a3c_96e1_0f7b_d248
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       csN,
  input  wire logic       hostClk,
  input  wire logic       serialIn,
  output logic            serialOut,
  output logic            serialOutOe,
  input  wire logic       portWidthSelect,
  input  wire logic [7:0] parallelBusLinesIn,
  output logic [7:0]      parallelBusLinesOut,
  output logic            parallelBusLinesOe,
  input  wire logic       resetPinN,
  output logic            busyOut,
  output logic            busyOe,
  output logic            standbyActive
);
  // id seed value is arbitrary
  fhi_host_t         hState;
  fhi_host_t         next_hState;
  fhi_eng_t          eState;
  fhi_kind_t         eKind;
  fhi_kind_t         pKind;
  logic [SYNC_W-1:0] pinSync;
  logic              sckPrev;
  logic              csPrev;
  logic [2:0]        bitCnt;
  logic [2:0]        obitCnt;
  logic [6:0]        inShift;
  logic [7:0]        outShift;
  logic [7:0]        opc;
  logic [15:0]       addr;
  logic [1:0]        byteCnt;
  logic [PAGE_W-1:0] ptrPage;
  logic [BYTE_W-1:0] ptrByte;
  logic              pend;
  logic              pBuf;
  logic [PAGE_W-1:0] pPage;
  logic              eBuf;
  logic [PAGE_W-1:0] ePage;
  logic [BYTE_W-1:0] eIdx;
  logic [BYTE_W-1:0] eIdxQ;
  logic              eValid;
  logic [TMR_W-1:0]  timer;
  logic              binMode;
  logic [7:0]        arrRd;
  logic [7:0]        secRd;
  logic [7:0]        secUser [64];
  logic [7:0]        arr [PAGES*int'(PAGE_STD_LEN)];
  logic [7:0]        hostRd [2];
  logic [7:0]        engRd [2];

  fhi_pin_sync #(.W(SYNC_W), .RST_VAL(SYNC_RST)) uSync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({csN, resetPinN, hostClk, serialIn, portWidthSelect, parallelBusLinesIn}),
    .q     (pinSync)
  );

  function automatic logic [ARR_W-1:0] arrIndex(input logic [PAGE_W-1:0] pg,
                                                input logic [BYTE_W-1:0] by);
    logic [PAGE_W-1:0] pm;
    pm = pg & PAGE_W'(PAGES - 1);
    arrIndex = ARR_W'(pm) * ARR_W'(PAGE_STD_LEN) + ARR_W'(by);
  endfunction : arrIndex

  function automatic logic [7:0] idByte(input logic [5:0] i);
    idByte = ID_SEED[{i[2:0], 3'h0} +: 8] ^ {2'h0, i};
  endfunction : idByte

  function automatic logic [TMR_W-1:0] waitOf(input fhi_kind_t k);
    case (k)
      K_PROG, K_SEC: waitOf = TMR_W'(PROG_CYC);
      K_ERASE:       waitOf = TMR_W'(ERASE_CYC);
      K_LOAD:        waitOf = TMR_W'(XFER_CYC);
      default:       waitOf = TMR_W'(CFG_CYC);
    endcase
  endfunction : waitOf

  // pin decode and edge detection
  wire       csS     = pinSync[12];
  wire       rstPinS = pinSync[11];
  wire       sckS    = pinSync[10];
  wire       siS     = pinSync[9];
  wire       serMode = pinSync[8];
  wire [7:0] busS    = pinSync[7:0];
  wire       sel     = ~csS & rstPinS;
  wire       sckRise = sel & sckS & ~sckPrev;
  wire       sckFall = sel & ~sckS & sckPrev;
  wire       csFallE = sel & csPrev;
  wire       csRiseE = csS & ~csPrev;
  wire       rxStrobe = sckRise & (~serMode | (bitCnt == BIT_LAST));
  wire [7:0] rxByte  = serMode ? {inShift, siS} : busS;

  // address and opcode decode
  wire [BYTE_W-1:0] pageLen  = binMode ? PAGE_BIN_LEN : PAGE_STD_LEN;
  wire [23:0]       fullAddr = {addr, rxByte};
  wire [PAGE_W-1:0] decPage  = binMode ? fullAddr[22:10] : fullAddr[23:11];
  wire [BYTE_W-1:0] decByte  = binMode ? {1'b0, fullAddr[9:0]} : fullAddr[10:0];
  wire rxKnown = rxByte inside {OPC_CONT_RD, OPC_BUF1_RD, OPC_BUF2_RD, OPC_BUF1_WR,
                                OPC_BUF2_WR, OPC_BUF1_PROG, OPC_BUF2_PROG, OPC_LOAD1,
                                OPC_LOAD2, OPC_PAGE_ERASE, OPC_SEC_RD, OPC_SEC_PROG,
                                OPC_BIN_PAGE};
  wire rdArr   = opc == OPC_CONT_RD;
  wire rdBuf   = opc inside {OPC_BUF1_RD, OPC_BUF2_RD};
  wire wrBuf   = opc inside {OPC_BUF1_WR, OPC_BUF2_WR};
  wire rdSec   = opc == OPC_SEC_RD;
  wire rdStat  = opc == OPC_STATUS;
  wire opcBuf  = opc inside {OPC_BUF2_RD, OPC_BUF2_WR, OPC_BUF2_PROG, OPC_LOAD2};
  wire engOpc  = opc inside {OPC_BUF1_PROG, OPC_BUF2_PROG, OPC_LOAD1, OPC_LOAD2,
                             OPC_PAGE_ERASE, OPC_SEC_PROG, OPC_BIN_PAGE};
  wire readCmd = rdArr | rdBuf | rdSec | rdStat;
  wire busy    = eState != E_IDLE;
  wire engUsesBuf = eKind inside {K_PROG, K_LOAD, K_SEC};
  wire bufBlocked = busy & engUsesBuf & (eBuf == opcBuf);
  wire cmdBlocked = ((rdArr | rdSec | engOpc) & busy) | ((rdBuf | wrBuf) & bufBlocked);
  wire addrDone = (hState == H_ADDR) & rxStrobe & (byteCnt == ADDR_LAST);
  wire dataRx   = (hState == H_DATA) & rxStrobe;
  wire outLoad  = (hState == H_DATA) & readCmd & sckFall & (~serMode | (obitCnt == 3'h0));
  wire advance  = (dataRx & wrBuf) | outLoad;
  wire lastByte = ptrByte == pageLen - 11'h001;
  fhi_kind_t opcKind;
  assign opcKind = (opc inside {OPC_BUF1_PROG, OPC_BUF2_PROG}) ? K_PROG :
                   (opc inside {OPC_LOAD1, OPC_LOAD2}) ? K_LOAD :
                   (opc == OPC_PAGE_ERASE) ? K_ERASE :
                   (opc == OPC_SEC_PROG) ? K_SEC : K_CFG;
  wire [7:0] statusByte = {~busy, 6'h00, binMode};
  wire [7:0] outByte = rdArr ? arrRd : rdBuf ? hostRd[opcBuf] : rdSec ? secRd : statusByte;

  // engine datapath selection
  wire [BYTE_W-1:0] eLen   = (eKind == K_SEC) ? SEC_USER_LEN : pageLen;
  wire              copying = eState == E_COPY;
  wire [7:0]        engSrc  = engRd[eBuf];
  wire              arrWe   = eValid & (eKind inside {K_PROG, K_ERASE});
  wire [7:0]        arrWd   = (eKind == K_ERASE) ? ERASED : engSrc;
  wire [ARR_W-1:0]  arrRdIdx = copying ? arrIndex(ePage, eIdx) : arrIndex(ptrPage, ptrByte);
  wire [ARR_W-1:0]  arrWrIdx = arrIndex(ePage, eIdxQ);
  wire              loadWe  = eValid & (eKind == K_LOAD);
  wire [BYTE_W-1:0] engAddr = (eKind == K_LOAD) ? eIdxQ : eIdx;

  // page buffers, host port on pointer, engine port on copy index
  fhi_buf_if bufIf [2] ();
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gBuf
      assign bufIf[g].hostWe   = dataRx & wrBuf & (opcBuf == 1'(g));
      assign bufIf[g].hostAddr = ptrByte;
      assign bufIf[g].hostWd   = rxByte;
      assign bufIf[g].engWe    = loadWe & (eBuf == 1'(g));
      assign bufIf[g].engAddr  = engAddr;
      assign bufIf[g].engWd    = arrRd;
      assign hostRd[g]         = bufIf[g].hostRd;
      assign engRd[g]          = bufIf[g].engRd;
      fhi_page_buf #(.DEPTH(int'(PAGE_STD_LEN))) uBuf (
        .clk  (clk),
        .port (bufIf[g].store)
      );
    end
  endgenerate

  always_ff @(posedge clk) begin
    arrRd <= arr[arrRdIdx];
    if (arrWe) begin
      arr[arrWrIdx] <= arrWd;
    end
  end

  // host command sequencer
  always_comb begin
    next_hState = hState;
    if (!sel) begin
      next_hState = H_IDLE;
    end else if (csFallE) begin
      next_hState = H_OPC;
    end else if (rxStrobe) begin
      case (hState)
        H_OPC:   next_hState = (rxByte == OPC_STATUS) ? H_DATA : rxKnown ? H_ADDR : H_SKIP;
        H_ADDR:  next_hState = (byteCnt != ADDR_LAST) ? H_ADDR : cmdBlocked ? H_SKIP : H_DATA;
        default: next_hState = hState;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hState  <= H_IDLE;
      sckPrev <= 1'b0;
      csPrev  <= 1'b1;
    end else begin
      hState  <= next_hState;
      sckPrev <= sckS;
      csPrev  <= csS;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitCnt  <= 3'h0;
      inShift <= 7'h00;
      opc     <= 8'h00;
      addr    <= 16'h0000;
      byteCnt <= 2'h0;
    end else if (!sel || csFallE) begin
      bitCnt  <= 3'h0;
      byteCnt <= 2'h0;
    end else if (sckRise) begin
      bitCnt  <= serMode ? bitCnt + 3'h1 : 3'h0;
      inShift <= {inShift[5:0], siS};
      if (rxStrobe && hState == H_OPC) begin
        opc <= rxByte;
      end
      if (rxStrobe && hState == H_ADDR) begin
        addr    <= fullAddr[15:0];
        byteCnt <= byteCnt + 2'h1;
      end
    end
  end

  // byte pointer and pending engine launch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptrPage <= '0;
      ptrByte <= '0;
      pend    <= 1'b0;
      pKind   <= K_CFG;
      pBuf    <= 1'b0;
      pPage   <= '0;
    end else begin
      if (addrDone) begin
        ptrPage <= decPage;
        ptrByte <= rdSec ? {4'h0, fullAddr[6:0]} : decByte;
      end else if (advance) begin
        ptrByte <= (lastByte && !rdSec) ? '0 : ptrByte + 11'h001;
        if (rdArr && lastByte) begin
          ptrPage <= ptrPage + 13'h0001;
        end
      end
      if (!rstPinS || csFallE || (csRiseE && !busy)) begin
        pend <= 1'b0;
      end else if (addrDone && engOpc && !cmdBlocked) begin
        pend  <= 1'b1;
        pKind <= opcKind;
        pBuf  <= opcBuf;
        pPage <= decPage;
      end
    end
  end

  // output shifter, driven on falling host clock only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serialOut           <= 1'b0;
      serialOutOe         <= 1'b0;
      parallelBusLinesOut <= 8'h00;
      parallelBusLinesOe  <= 1'b0;
      outShift            <= 8'h00;
      obitCnt             <= 3'h0;
    end else if (!sel) begin
      serialOutOe        <= 1'b0;
      parallelBusLinesOe <= 1'b0;
      obitCnt            <= 3'h0;
    end else if (sckFall && hState == H_DATA && readCmd) begin
      if (serMode) begin
        serialOutOe <= 1'b1;
        obitCnt     <= obitCnt + 3'h1;
        serialOut   <= (obitCnt == 3'h0) ? outByte[7] : outShift[7];
        outShift    <= (obitCnt == 3'h0) ? {outByte[6:0], 1'b0} : {outShift[6:0], 1'b0};
      end else begin
        parallelBusLinesOe  <= 1'b1;
        parallelBusLinesOut <= outByte;
      end
    end
  end

  // security area, user half written by the engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      secRd <= 8'h00;
      for (int i = 0; i < 64; i++) begin
        secUser[i] <= ERASED;
      end
    end else begin
      secRd <= ptrByte[6] ? idByte(ptrByte[5:0]) : secUser[ptrByte[5:0]];
      if (eValid && eKind == K_SEC) begin
        secUser[eIdxQ[5:0]] <= engSrc;
      end
    end
  end

  // self-timed engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eState  <= E_IDLE;
      eKind   <= K_CFG;
      eBuf    <= 1'b0;
      ePage   <= '0;
      eIdx    <= '0;
      timer   <= '0;
      binMode <= 1'b0;
    end else if (!rstPinS) begin
      eState <= E_IDLE;
    end else begin
      case (eState)
        E_IDLE: begin
          if (csRiseE && pend) begin
            eKind  <= pKind;
            eBuf   <= (pKind == K_SEC) ? 1'b0 : pBuf;
            ePage  <= pPage;
            eIdx   <= '0;
            timer  <= waitOf(pKind);
            eState <= (pKind == K_CFG) ? E_WAIT : E_COPY;
          end
        end
        E_COPY: begin
          eIdx <= eIdx + 11'h001;
          if (eIdx == eLen - 11'h001) begin
            eState <= E_WAIT;
          end
        end
        E_WAIT: begin
          if (timer == '0) begin
            eState <= E_IDLE;
            if (eKind == K_CFG) begin
              binMode <= 1'b1;
            end
          end else begin
            timer <= timer - 16'h0001;
          end
        end
        default: eState <= E_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eValid        <= 1'b0;
      eIdxQ         <= '0;
      busyOut       <= 1'b0;
      busyOe        <= 1'b0;
      standbyActive <= 1'b0;
    end else begin
      eValid        <= copying & rstPinS;
      eIdxQ         <= eIdx;
      busyOut       <= 1'b0;
      busyOe        <= busy & rstPinS;
      standbyActive <= csS & ~busy;
    end
  end
endmodule : fhi_flash_front
`default_nettype wire

// file: verilog/fhi_pkg.sv
// constants, opcodes and state types for the flash host front end
package fhi_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TIME_NS  = 20000;
  localparam int ERASE_TIME_NS = 15000;
  localparam int XFER_TIME_NS  = 2000;
  localparam int CFG_TIME_NS   = 2000;
  localparam int PROG_CYC  = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYC = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int XFER_CYC  = (XFER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CFG_CYC   = (CFG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W  = 16;
  localparam int PAGE_W = 13;
  localparam int BYTE_W = 11;
  localparam int ARR_W  = 24;
  localparam int SYNC_W = 13;
  localparam logic [SYNC_W-1:0] SYNC_RST     = 13'h1800;
  localparam logic [BYTE_W-1:0] PAGE_STD_LEN = 11'h420;
  localparam logic [BYTE_W-1:0] PAGE_BIN_LEN = 11'h400;
  localparam logic [BYTE_W-1:0] SEC_USER_LEN = 11'h040;
  localparam logic [1:0]        ADDR_LAST    = 2'h2;
  localparam logic [2:0]        BIT_LAST     = 3'h7;
  localparam logic [7:0]        ERASED       = 8'hff;
  localparam logic [7:0] OPC_CONT_RD    = 8'h0b;
  localparam logic [7:0] OPC_BUF1_RD    = 8'hd1;
  localparam logic [7:0] OPC_BUF2_RD    = 8'hd3;
  localparam logic [7:0] OPC_BUF1_WR    = 8'h84;
  localparam logic [7:0] OPC_BUF2_WR    = 8'h87;
  localparam logic [7:0] OPC_BUF1_PROG  = 8'h83;
  localparam logic [7:0] OPC_BUF2_PROG  = 8'h86;
  localparam logic [7:0] OPC_LOAD1      = 8'h53;
  localparam logic [7:0] OPC_LOAD2      = 8'h55;
  localparam logic [7:0] OPC_PAGE_ERASE = 8'h81;
  localparam logic [7:0] OPC_SEC_RD     = 8'h77;
  localparam logic [7:0] OPC_SEC_PROG   = 8'h9b;
  localparam logic [7:0] OPC_STATUS     = 8'hd7;
  localparam logic [7:0] OPC_BIN_PAGE   = 8'h3d;
  typedef enum logic [4:0] {
    H_IDLE = 5'h01, H_OPC = 5'h02, H_ADDR = 5'h04, H_DATA = 5'h08, H_SKIP = 5'h10
  } fhi_host_t;
  typedef enum logic [2:0] {E_IDLE = 3'h1, E_COPY = 3'h2, E_WAIT = 3'h4} fhi_eng_t;
  typedef enum logic [2:0] {
    K_PROG = 3'h0, K_LOAD = 3'h1, K_ERASE = 3'h2, K_SEC = 3'h3, K_CFG = 3'h4
  } fhi_kind_t;
endpackage : fhi_pkg

// file: verilog/fhi_buf_if.sv
// two-port connection between the front end and one page buffer
`timescale 1ns/1ps
`default_nettype none
interface fhi_buf_if import fhi_pkg::*; ();
  logic              hostWe;
  logic [BYTE_W-1:0] hostAddr;
  logic [7:0]        hostWd;
  logic [7:0]        hostRd;
  logic              engWe;
  logic [BYTE_W-1:0] engAddr;
  logic [7:0]        engWd;
  logic [7:0]        engRd;
  modport owner (output hostWe, hostAddr, hostWd, engWe, engAddr, engWd,
                 input hostRd, engRd);
  modport store (input hostWe, hostAddr, hostWd, engWe, engAddr, engWd,
                 output hostRd, engRd);
endinterface : fhi_buf_if
`default_nettype wire

// file: verilog/fhi_pin_sync.sv
// two-flop synchroniser for the host pins
`timescale 1ns/1ps
`default_nettype none
module fhi_pin_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q
);
  logic [W-1:0] stage;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage <= RST_VAL;
      q     <= RST_VAL;
    end else begin
      stage <= d;
      q     <= stage;
    end
  end
endmodule : fhi_pin_sync
`default_nettype wire

// file: verilog/fhi_page_buf.sv
// one sram page buffer, host port and engine port
`timescale 1ns/1ps
`default_nettype none
module fhi_page_buf #(
  parameter int DEPTH = 1056
) (
  input wire logic clk,
  fhi_buf_if.store port
);
  logic [7:0] mem [DEPTH];
  always_ff @(posedge clk) begin
    if (port.hostWe) begin
      mem[port.hostAddr] <= port.hostWd;
    end
    if (port.engWe) begin
      mem[port.engAddr] <= port.engWd;
    end
    port.hostRd <= mem[port.hostAddr];
    port.engRd  <= mem[port.engAddr];
  end
endmodule : fhi_page_buf
`default_nettype wire

// file: testbench/fhi_monitor.sv
// assertion checker on the ports of the flash host front end
`timescale 1ns/1ps
`default_nettype none
module fhi_monitor (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       csN,
  input wire logic       hostClk,
  input wire logic       portWidthSelect,
  input wire logic       resetPinN,
  input wire logic       serialOut,
  input wire logic       serialOutOe,
  input wire logic [7:0] parallelBusLinesOut,
  input wire logic       parallelBusLinesOe,
  input wire logic       busyOe,
  input wire logic       standbyActive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_DESEL_FLOAT: assert property (csN [*6] |-> !serialOutOe && !parallelBusLinesOe)
    else $error("outputs driven while deselected");
  AST_OE_SELECTED: assert property (($rose(serialOutOe) || $rose(parallelBusLinesOe))
    |-> !$past(csN) && !$past(csN, 2) && !$past(csN, 3))
    else $error("output enabled without select");
  AST_SER_FALL: assert property (serialOutOe && $changed(serialOut)
    |-> !$past(hostClk) && !$past(hostClk, 2))
    else $error("serial output changed outside host clock low phase");
  AST_PAR_FALL: assert property (parallelBusLinesOe && $changed(parallelBusLinesOut)
    |-> !$past(hostClk) && !$past(hostClk, 2))
    else $error("parallel output changed outside host clock low phase");
  AST_STANDBY_BUSY: assert property (busyOe && $past(busyOe) |-> !standbyActive)
    else $error("standby entered while busy");
  AST_STANDBY_AFTER: assert property ($fell(busyOe) && resetPinN && csN && $past(csN)
    && $past(csN, 2) && $past(csN, 3) |-> standbyActive)
    else $error("standby not entered after timed operation");
  AST_BUSY_LAUNCH: assert property ($rose(busyOe) |-> $past(csN) && $past(csN, 2))
    else $error("busy started inside a frame");
  AST_BUSY_HOLD: assert property ($rose(busyOe) |=> (busyOe || !resetPinN) [*8])
    else $error("timed operation ended too soon");
  AST_RESET_PIN: assert property (!resetPinN [*5]
    |-> !busyOe && !serialOutOe && !parallelBusLinesOe)
    else $error("activity while reset pin low");
  AST_PORT_SEL: assert property ((serialOutOe |-> portWidthSelect)
    and (parallelBusLinesOe |-> !portWidthSelect))
    else $error("unselected port driven");
endmodule : fhi_monitor
bind fhi_flash_front fhi_monitor u_mon (.clk, .rst_n, .csN, .hostClk, .portWidthSelect,
  .resetPinN, .serialOut, .serialOutOe, .parallelBusLinesOut, .parallelBusLinesOe,
  .busyOe, .standbyActive);
`default_nettype wire

// file: testbench/fhi_host_model.sv
// host controller model driving the front end pins
`timescale 1ns/1ps
`default_nettype none
module fhi_host_model #(
  parameter int HALF = 5
) (
  input  wire logic       clk,
  input  wire logic       serialOut,
  input  wire logic [7:0] parallelBusLinesOut,
  output var  logic       csN,
  output var  logic       hostClk,
  output var  logic       serialIn,
  output var  logic [7:0] hostBus,
  output var  logic       portWidthSelect
);
  logic idleHigh;
  initial begin
    csN = 1'b1;
    hostClk = 1'b0;
    serialIn = 1'b0;
    hostBus = 8'h00;
    portWidthSelect = 1'b1;
    idleHigh = 1'b0;
  end
  // clock parked at the idle level of the chosen mode
  task automatic start(input logic ser, input logic mode3);
    @(posedge clk);
    portWidthSelect <= ser;
    hostClk <= mode3;
    idleHigh <= mode3;
    repeat (6) @(posedge clk);
    csN <= 1'b0;
    repeat (HALF) @(posedge clk);
  endtask : start
  task automatic beat(input logic [7:0] d, input logic rd, output logic [7:0] q);
    @(posedge clk);
    hostClk <= 1'b0;
    serialIn <= rd ? ~serialIn : d[7];
    hostBus <= rd ? ~hostBus : d;
    repeat (HALF) @(posedge clk);
    #1;
    q = portWidthSelect ? {7'h00, serialOut} : parallelBusLinesOut;
    @(posedge clk);
    hostClk <= 1'b1;
    repeat (HALF) @(posedge clk);
  endtask : beat
  task automatic xbyte(input logic [7:0] d, input logic rd, output logic [7:0] q);
    logic [7:0] b;
    for (int i = 0; i < (portWidthSelect ? 8 : 1); i++) begin
      beat(d << i, rd, b);
      q = portWidthSelect ? {q[6:0], b[0]} : b;
    end
  endtask : xbyte
  task automatic cmd(input logic [7:0] opc, input logic [23:0] a);
    logic [7:0] q;
    xbyte(opc, 1'b0, q);
    for (int i = 2; i >= 0; i--) xbyte(a[8*i +: 8], 1'b0, q);
  endtask : cmd
  // released lines show an inverted value, not the last one
  task automatic stop();
    @(posedge clk);
    hostClk <= idleHigh;
    repeat (HALF) @(posedge clk);
    csN <= 1'b1;
    repeat (8) @(posedge clk);
    serialIn <= ~serialIn;
    hostBus <= ~hostBus;
  endtask : stop
endmodule : fhi_host_model
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the flash host front end
`timescale 1ns/1ps
`default_nettype none
module tb import fhi_pkg::*; ();
  logic       clk, rst_n, resetPinN, csN, hostClk, serialIn, portWidthSelect;
  logic       serialOut, serialOutOe, parallelBusLinesOe, busyOut, busyOe, standbyActive;
  logic       busyWire;
  logic [7:0] hostBus, busLines, parallelBusLinesOut;
  int         nMismatch = 0;
  int         numChecks = 0;
  assign busLines = parallelBusLinesOe ? parallelBusLinesOut : hostBus;
  assign busyWire = busyOe ? busyOut : 1'b1;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  fhi_flash_front i_dut (.clk, .rst_n, .csN, .hostClk, .serialIn, .serialOut, .serialOutOe,
    .portWidthSelect, .parallelBusLinesIn(busLines), .parallelBusLinesOut,
    .parallelBusLinesOe, .resetPinN, .busyOut, .busyOe, .standbyActive);
  fhi_host_model i_host (.clk, .serialOut, .parallelBusLinesOut, .csN, .hostClk, .serialIn,
    .hostBus, .portWidthSelect);
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    numChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check8
  task automatic check1(input string name, input logic exp, input logic got);
    numChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask : check1
  task automatic waitBusy(input logic lvl);
    int n;
    n = 0;
    #1;
    while (busyOe !== lvl && n < 6000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check1("busyOe", lvl, busyOe);
  endtask : waitBusy
  task automatic op(input logic ser, input logic [7:0] opc, input logic [23:0] a);
    i_host.start(ser, 1'b0);
    i_host.cmd(opc, a);
    i_host.stop();
  endtask : op
  task automatic wr2(input logic ser, input logic [7:0] opc, input logic [23:0] a,
                     input logic [7:0] d0, d1);
    logic [7:0] q;
    i_host.start(ser, 1'b0);
    i_host.cmd(opc, a);
    i_host.xbyte(d0, 1'b0, q);
    i_host.xbyte(d1, 1'b0, q);
    i_host.stop();
  endtask : wr2
  task automatic rd2(input logic ser, m3, input logic [7:0] opc, input logic [23:0] a,
                     input logic [7:0] e0, e1);
    logic [7:0] q;
    i_host.start(ser, m3);
    i_host.cmd(opc, a);
    i_host.xbyte(8'h00, 1'b1, q);
    check8("read0", e0, q);
    i_host.xbyte(8'h00, 1'b1, q);
    check8("read1", e1, q);
    i_host.stop();
  endtask : rd2
  task automatic statusChk(input logic [7:0] exp);
    logic [7:0] q;
    i_host.start(1'b1, 1'b0);
    i_host.xbyte(OPC_STATUS, 1'b0, q);
    i_host.xbyte(8'h00, 1'b1, q);
    i_host.stop();
    check8("status", exp, q);
  endtask : statusChk
  task automatic t_deselect();
    logic [7:0] q;
    for (int i = 0; i < 16; i++) i_host.beat(OPC_BUF1_WR, 1'b0, q);
    @(posedge clk);
    #1;
    check1("outEnable", 1'b0, serialOutOe | parallelBusLinesOe);
    check1("standby", 1'b1, standbyActive);
    statusChk(8'h80);
    $display("test deselect done");
  endtask : t_deselect
  task automatic t_serial();
    wr2(1'b1, OPC_BUF1_WR, 24'h000000, 8'ha5, 8'h3c);
    wr2(1'b1, OPC_BUF1_WR, 24'h00041f, 8'hc3, 8'h5a);
    rd2(1'b1, 1'b1, OPC_BUF1_RD, 24'h000000, 8'h5a, 8'h3c);
    rd2(1'b1, 1'b0, OPC_BUF1_RD, 24'h00041f, 8'hc3, 8'h5a);
    $display("test serial done");
  endtask : t_serial
  task automatic t_parallel();
    wr2(1'b0, OPC_BUF2_WR, 24'h000010, 8'h11, 8'h22);
    rd2(1'b0, 1'b0, OPC_BUF2_RD, 24'h000010, 8'h11, 8'h22);
    $display("test parallel done");
  endtask : t_parallel
  task automatic t_program();
    op(1'b1, OPC_BUF1_PROG, 24'h000800);
    waitBusy(1'b1);
    check1("standby", 1'b0, standbyActive);
    check1("busyPin", 1'b0, busyWire);
    wr2(1'b0, OPC_BUF2_WR, 24'h000020, 8'h77, 8'h88);
    rd2(1'b0, 1'b0, OPC_BUF2_RD, 24'h000020, 8'h77, 8'h88);
    waitBusy(1'b0);
    repeat (6) @(posedge clk);
    #1;
    check1("standby", 1'b1, standbyActive);
    op(1'b1, OPC_PAGE_ERASE, 24'h001000);
    waitBusy(1'b1);
    waitBusy(1'b0);
    rd2(1'b0, 1'b0, OPC_CONT_RD, 24'h000c1f, 8'hc3, ERASED);
    op(1'b1, OPC_LOAD2, 24'h000800);
    waitBusy(1'b1);
    waitBusy(1'b0);
    rd2(1'b0, 1'b0, OPC_BUF2_RD, 24'h000000, 8'h5a, 8'h3c);
    $display("test program done");
  endtask : t_program
  task automatic t_reset_pin();
    op(1'b1, OPC_BUF1_PROG, 24'h000800);
    waitBusy(1'b1);
    @(posedge clk) resetPinN <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    check1("busyAbort", 1'b0, busyOe);
    @(posedge clk) resetPinN <= 1'b1;
    repeat (6) @(posedge clk);
    statusChk(8'h80);
    $display("test reset pin done");
  endtask : t_reset_pin
  // binary page setting is sticky, so this runs last
  task automatic t_modes();
    op(1'b1, OPC_SEC_PROG, 24'h000000);
    waitBusy(1'b1);
    waitBusy(1'b0);
    rd2(1'b1, 1'b1, OPC_SEC_RD, 24'h000000, 8'h5a, 8'h3c);
    op(1'b0, OPC_BIN_PAGE, 24'h000000);
    waitBusy(1'b1);
    waitBusy(1'b0);
    statusChk(8'h81);
    wr2(1'b0, OPC_BUF2_WR, 24'h0003ff, 8'h12, 8'h34);
    rd2(1'b0, 1'b0, OPC_BUF2_RD, 24'h0003ff, 8'h12, 8'h34);
    $display("test modes done");
  endtask : t_modes
  initial begin
    rst_n = 1'b0;
    resetPinN = 1'b1;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    t_deselect();
    t_serial();
    t_parallel();
    t_program();
    t_reset_pin();
    t_modes();
    tally_and_finish();
  end
  initial begin
    repeat (60000) @(posedge clk);
    nMismatch++;
    $display("watchdog expired");
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
